// [verilog/alert_pkg.sv]
// Package for the alert mask, enable and flag logic of a power monitor.
// Assumes a single device clock domain and a register access port that
// presents one 16-bit register at a time.
package alert_pkg;
   localparam logic [5:0]  MASK_REG_INDEX  = 6'h06;
   localparam logic [5:0]  CONFIG_REG_INDEX = 6'h00;
   localparam logic [15:0] MASK_REG_RESET  = 16'h0000;
   localparam int SHUNT_OVER_BIT  = 15;
   localparam int SHUNT_UNDER_BIT = 14;
   localparam int BUS_OVER_BIT    = 13;
   localparam int BUS_UNDER_BIT   = 12;
   localparam int POWER_OVER_BIT  = 11;
   localparam int READY_ALERT_BIT = 10;
   localparam int STORAGE_ERR_BIT = 5;
   localparam int ALERT_FLAG_BIT  = 4;
   localparam int READY_FLAG_BIT  = 3;
   localparam int OVERFLOW_BIT    = 2;
   localparam int POLARITY_BIT    = 1;
   localparam int LATCH_BIT       = 0;
   localparam int RESULT_WIDTH    = 16;
   typedef enum logic [2:0] {
      FUNC_NONE,
      FUNC_SHUNT_OVER,
      FUNC_SHUNT_UNDER,
      FUNC_BUS_OVER,
      FUNC_BUS_UNDER,
      FUNC_POWER_OVER
   } limit_func_t;
endpackage

// [verilog/limit_compare.sv]
// Limit comparison for the one selected alert function.
// Assumes results and limit share the format of the targeted register.
`timescale 1ns/1ns
module limit_compare #(
   parameter int WIDTH = 16
) (
   // Selection
   input  wire alert_pkg::limit_func_t func_in,
   // Operands
   input  wire logic [WIDTH-1:0] shunt_in,
   input  wire logic [WIDTH-1:0] bus_in,
   input  wire logic [WIDTH-1:0] power_in,
   input  wire logic [WIDTH-1:0] limit_in,
   // Result
   output logic                  fault_out
);
   // A one-bit operand leaves no room for the sign of a shunt value.
   if (WIDTH < 2) begin
      $error("limit_compare: WIDTH too small");
   end

   // Shunt values are signed; bus and power are unsigned.
   always_comb begin
      unique case (func_in)
         alert_pkg::FUNC_SHUNT_OVER:  fault_out = $signed(shunt_in) > $signed(limit_in);
         alert_pkg::FUNC_SHUNT_UNDER: fault_out = $signed(shunt_in) < $signed(limit_in);
         alert_pkg::FUNC_BUS_OVER:    fault_out = bus_in > limit_in;
         alert_pkg::FUNC_BUS_UNDER:   fault_out = bus_in < limit_in;
         alert_pkg::FUNC_POWER_OVER:  fault_out = power_in > limit_in;
         default:                     fault_out = 1'b0;
      endcase
   end
endmodule

// [verilog/alert_mask_enable.sv]
// Alert mask and enable register with flag and alert pin logic.
// Assumes the converter pulses cycle_done_in once averaging and products are
// finished, with the averaged results stable on the result inputs.
// Notes on behaviour
// - Shunt over enable alerts when shunt result exceeds the limit.
// - Shunt under enable refused while shunt over is set; alerts below limit.
// - Bus over alerts above limit; refused while a shunt enable is set.
// - Bus under alerts below limit; refused while a shunt enable or bus over is set.
// - Power over alerts above limit; refused while any other limit enable set.
// - Ready-on-alert enable lets the ready flag drive the alert pin.
// - One limit function at a time, plus the ready event on the pin.
// - Latched: alert function flag holds until this register is read.
// - Transparent: flag clears after the next conversion without a fault.
// - Ready flag sets only after conversions, averaging and products finish.
// - Configuration writes clear the ready flag, except power-down-only writes.
// - Reading this register clears the ready flag.
// - Latest results stay readable regardless of the ready flag.
// - Math overflow bit reads one when an arithmetic overflow occurs.
// - Polarity zero gives active-low open drain; one gives active-high.
// - Transparent: pin and flag go idle once the fault is gone.
// - Latched: pin and flag stay active until this register is read.
`timescale 1ns/1ns
module alert_mask_enable #(
   parameter int WIDTH = alert_pkg::RESULT_WIDTH
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   // Register access port
   input  wire logic [5:0]       reg_index_in,
   input  wire logic             reg_write_in,
   input  wire logic             reg_read_in,
   input  wire logic [15:0]      reg_wdata_in,
   input  wire logic             config_power_down_only_in,
   output logic      [15:0]      reg_rdata_out,
   // Converter side
   input  wire logic             cycle_done_in,
   input  wire logic [WIDTH-1:0] shunt_in,
   input  wire logic [WIDTH-1:0] bus_in,
   input  wire logic [WIDTH-1:0] power_in,
   input  wire logic [WIDTH-1:0] limit_in,
   input  wire logic             overflow_event_in,
   input  wire logic             storage_error_event_in,
   // Alert pin, open drain at polarity zero, driven both ways at polarity one
   output logic                  alert_o_out,
   output logic                  alert_oen_n_out
);
   // The limit and the results share the one 16-bit register format.
   if (WIDTH != 16) begin
      $error("alert_mask_enable: register holds 16-bit results only");
   end

   logic        shunt_over_enable;
   logic        shunt_under_enable;
   logic        bus_over_enable;
   logic        bus_under_enable;
   logic        power_over_enable;
   logic        ready_on_alert_enable;
   logic        alert_polarity;
   logic        alert_latch_select;
   logic        alert_function_flag;
   logic        conversion_ready_flag;
   logic        math_overflow;
   logic        storage_error;
   logic        fault;
   logic        mask_write;
   logic        mask_read;
   logic        config_write;
   logic        alert_active;
   logic [15:0] mask_word;
   alert_pkg::limit_func_t func;

   // Other indexes pass by, except that a configuration write that is not power-down-only clears the ready flag.
   assign mask_write   = reg_write_in && (reg_index_in == alert_pkg::MASK_REG_INDEX);
   assign mask_read    = reg_read_in && (reg_index_in == alert_pkg::MASK_REG_INDEX);
   assign config_write = reg_write_in && (reg_index_in == alert_pkg::CONFIG_REG_INDEX);

   // Each write is checked against the enables already held, so a later
   // function bit cannot join an earlier one.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         shunt_over_enable     <= 1'b0;
         shunt_under_enable    <= 1'b0;
         bus_over_enable       <= 1'b0;
         bus_under_enable      <= 1'b0;
         power_over_enable     <= 1'b0;
         ready_on_alert_enable <= 1'b0;
         alert_polarity        <= 1'b0;
         alert_latch_select    <= 1'b0;
      end else if (mask_write) begin
         shunt_over_enable     <= reg_wdata_in[alert_pkg::SHUNT_OVER_BIT];
         shunt_under_enable    <= reg_wdata_in[alert_pkg::SHUNT_UNDER_BIT]
                                  && !shunt_over_enable;
         bus_over_enable       <= reg_wdata_in[alert_pkg::BUS_OVER_BIT]
                                  && !shunt_over_enable && !shunt_under_enable;
         bus_under_enable      <= reg_wdata_in[alert_pkg::BUS_UNDER_BIT]
                                  && !shunt_over_enable && !shunt_under_enable
                                  && !bus_over_enable;
         power_over_enable     <= reg_wdata_in[alert_pkg::POWER_OVER_BIT]
                                  && !shunt_over_enable && !shunt_under_enable
                                  && !bus_over_enable && !bus_under_enable;
         ready_on_alert_enable <= reg_wdata_in[alert_pkg::READY_ALERT_BIT];
         alert_polarity        <= reg_wdata_in[alert_pkg::POLARITY_BIT];
         alert_latch_select    <= reg_wdata_in[alert_pkg::LATCH_BIT];
      end
   end

   // If a write lands two bits at once, the highest one wins.
   always_comb begin
      if (shunt_over_enable) begin
         func = alert_pkg::FUNC_SHUNT_OVER;
      end else if (shunt_under_enable) begin
         func = alert_pkg::FUNC_SHUNT_UNDER;
      end else if (bus_over_enable) begin
         func = alert_pkg::FUNC_BUS_OVER;
      end else if (bus_under_enable) begin
         func = alert_pkg::FUNC_BUS_UNDER;
      end else if (power_over_enable) begin
         func = alert_pkg::FUNC_POWER_OVER;
      end else begin
         func = alert_pkg::FUNC_NONE;
      end
   end

   limit_compare #(
      .WIDTH (WIDTH)
   ) u_compare (
      .func_in   (func),
      .shunt_in  (shunt_in),
      .bus_in    (bus_in),
      .power_in  (power_in),
      .limit_in  (limit_in),
      .fault_out (fault)
   );

   // A fault seen at a cycle end sets the flag; that beats a read in the same cycle.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_function_flag <= 1'b0;
      end else if (cycle_done_in && fault) begin
         alert_function_flag <= 1'b1;
      end else if (alert_latch_select && mask_read) begin
         alert_function_flag <= 1'b0;
      end else if (!alert_latch_select && cycle_done_in) begin
         alert_function_flag <= 1'b0;
      end
   end

   // A conversion end beats a read or a configuration write in the same cycle,
   // so no finished result goes unannounced.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         conversion_ready_flag <= 1'b0;
      end else if (cycle_done_in) begin
         conversion_ready_flag <= 1'b1;
      end else if (mask_read || (config_write && !config_power_down_only_in)) begin
         conversion_ready_flag <= 1'b0;
      end
   end

   // Sticky status; reading does not clear them.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         math_overflow <= 1'b0;
         storage_error <= 1'b0;
      end else begin
         if (overflow_event_in) begin
            math_overflow <= 1'b1;
         end
         if (storage_error_event_in) begin
            storage_error <= 1'b1;
         end
      end
   end

   // Reserved bits 9 to 6 keep their reset value of zero.
   always_comb begin
      mask_word = alert_pkg::MASK_REG_RESET;
      mask_word[alert_pkg::SHUNT_OVER_BIT]  = shunt_over_enable;
      mask_word[alert_pkg::SHUNT_UNDER_BIT] = shunt_under_enable;
      mask_word[alert_pkg::BUS_OVER_BIT]    = bus_over_enable;
      mask_word[alert_pkg::BUS_UNDER_BIT]   = bus_under_enable;
      mask_word[alert_pkg::POWER_OVER_BIT]  = power_over_enable;
      mask_word[alert_pkg::READY_ALERT_BIT] = ready_on_alert_enable;
      mask_word[alert_pkg::STORAGE_ERR_BIT] = storage_error;
      mask_word[alert_pkg::ALERT_FLAG_BIT]  = alert_function_flag;
      mask_word[alert_pkg::READY_FLAG_BIT]  = conversion_ready_flag;
      mask_word[alert_pkg::OVERFLOW_BIT]    = math_overflow;
      mask_word[alert_pkg::POLARITY_BIT]    = alert_polarity;
      mask_word[alert_pkg::LATCH_BIT]       = alert_latch_select;
   end

   // Read data is registered; results live elsewhere and are never gated here.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (mask_read) begin
         reg_rdata_out <= mask_word;
      end
   end

   // The flag moves only at cycle ends and on reads in latched mode, so the pin cannot chatter between them.
   assign alert_active = alert_function_flag
                         || (ready_on_alert_enable && conversion_ready_flag);

   // Normal sense only sinks the line; inverted sense drives it high.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_o_out     <= 1'b0;
         alert_oen_n_out <= 1'b1;
      end else if (alert_polarity) begin
         alert_o_out     <= alert_active;
         alert_oen_n_out <= 1'b0;
      end else begin
         alert_o_out     <= 1'b0;
         alert_oen_n_out <= !alert_active;
      end
   end
endmodule

// [sim/alert_mask_enable_sva.sv]
// Checker for the alert mask register, its flags and the alert pin.
// Assumes one-cycle strobes, as the bench drives them, bound at the top.
`timescale 1ns/1ns
module alert_mask_enable_sva (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rstn_in,
   // Watched ports
   input wire logic [5:0]  reg_index_in,
   input wire logic        reg_write_in,
   input wire logic        reg_read_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        cycle_done_in,
   input wire logic        overflow_event_in,
   input wire logic        storage_error_event_in,
   input wire logic        alert_oen_n_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   sequence s_rd;
      reg_read_in && reg_index_in == 6'h06;
   endsequence
   sequence s_quiet_rd;
      reg_read_in && reg_index_in == 6'h06 && !cycle_done_in;
   endsequence
   sequence s_wr_top;
      reg_write_in && reg_index_in == 6'h06 && reg_wdata_in[15];
   endsequence
   chk_rdata_holds: assert property (!(reg_read_in && reg_index_in == 6'h06) |=>
      $stable(reg_rdata_out)) else $error("read data moved without a read");
   chk_ready_seen: assert property (cycle_done_in ##2 s_rd |=> reg_rdata_out[3])
      else $error("ready flag missing after a conversion");
   chk_ready_cleared: assert property (s_quiet_rd ##1 !cycle_done_in ##1 s_quiet_rd
      |=> !reg_rdata_out[3]) else $error("ready flag survived a read");
   chk_overflow_kept: assert property (overflow_event_in ##[1:4] s_rd |=>
      reg_rdata_out[2]) else $error("overflow bit missing");
   chk_storage_kept: assert property (storage_error_event_in ##[1:4] s_rd |=>
      reg_rdata_out[5]) else $error("storage error bit missing");
   chk_polarity_drive: assert property (reg_write_in && reg_index_in == 6'h06
      && reg_wdata_in[1] |-> ##2 !alert_oen_n_out) else $error("inverted pin not driven");
   chk_lower_refused: assert property (s_wr_top ##2 s_wr_top ##2 s_rd |=>
      reg_rdata_out[15:11] == 5'h10) else $error("lower limit enable accepted");
   chk_idle_no_flag: assert property (reg_write_in && reg_index_in == 6'h06
      && reg_wdata_in[15:11] == 5'h00 && !reg_wdata_in[0] ##2 cycle_done_in ##2 s_rd
      |=> !reg_rdata_out[4]) else $error("flag set with no function");
endmodule

// [sim/alert_host_model.sv]
// Host side of the alert line: a pulled-up open-drain wire.
// Assumes nothing else drives the line.
`timescale 1ns/1ns
module alert_host_model (
   // Pin from the device
   input  wire logic alert_o_in,
   input  wire logic alert_oen_n_in,
   // Level the host sees
   output logic      alert_level_out
);
   // A released line floats high through the pull-up.
   assign alert_level_out = alert_oen_n_in ? 1'b1 : alert_o_in;
endmodule

// [sim/test_alert_mask_enable.sv]
// Testbench for the alert mask register, flags and alert pin.
// Assumes the host model resolves the pin and the checker is bound below.
`timescale 1ns/1ns
module test_alert_mask_enable;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [5:0]  reg_index_in = 6'h00;
   logic        reg_write_in = 1'b0;
   logic        reg_read_in = 1'b0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        config_power_down_only_in = 1'b0;
   logic [15:0] reg_rdata_out;
   logic        cycle_done_in = 1'b0;
   logic [15:0] shunt_in = 16'h0000;
   logic [15:0] bus_in = 16'h0000;
   logic [15:0] power_in = 16'h0000;
   logic [15:0] limit_in = 16'h0080;
   logic        overflow_event_in = 1'b0;
   logic        storage_error_event_in = 1'b0;
   logic        alert_o_out;
   logic        alert_oen_n_out;
   logic        alert_level;
   logic [15:0] w;
   int          mismatches = 0;
   int          checked = 0;
   int          cycles = 0;
   alert_mask_enable dut (.*);
   alert_host_model host (.alert_o_in(alert_o_out), .alert_oen_n_in(alert_oen_n_out),
      .alert_level_out(alert_level));
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   task automatic wrap_up();
      $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // A stuck design would hang the run, so a ceiling cuts it short.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] i, input logic [15:0] d);
      @(posedge clk_in);
      reg_index_in <= i;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clk_in);
      reg_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] e);
      @(posedge clk_in);
      reg_index_in <= 6'h06;
      reg_read_in <= 1'b1;
      @(posedge clk_in);
      reg_read_in <= 1'b0;
      #1 chk("mask word", e, reg_rdata_out);
   endtask
   task automatic dn(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p);
      @(posedge clk_in);
      shunt_in <= s;
      bus_in <= b;
      power_in <= p;
      cycle_done_in <= 1'b1;
      @(posedge clk_in);
      cycle_done_in <= 1'b0;
   endtask
   task automatic pin(input logic e);
      repeat (2) @(posedge clk_in);
      #1 chk("alert level", {15'h0000, e}, {15'h0000, alert_level});
   endtask
   task automatic t_shunt_latched();
      rd(16'h0000);
      wr(6'h06, 16'h8001);
      dn(16'hFF00, 16'h0000, 16'h0000);
      pin(1'b1);
      dn(16'h0100, 16'h0000, 16'h0000);
      pin(1'b0);
      dn(16'h0010, 16'h0000, 16'h0000);
      pin(1'b0);
      rd(16'h8019);
      rd(16'h8001);
      pin(1'b1);
      $display("shunt latched test done");
   endtask
   task automatic t_priority();
      for (int k = 0; k < 4; k++) begin
         w = 16'h8000 >> k;
         wr(6'h06, 16'h0000);
         wr(6'h06, w);
         wr(6'h06, ((w << 1) - 16'h0001) & 16'hF800);
         rd(w);
      end
      $display("priority test done");
   endtask
   task automatic t_bus_inverted();
      wr(6'h06, 16'h1002);
      dn(16'h0000, 16'h0010, 16'h0000);
      pin(1'b1);
      dn(16'h0000, 16'h0300, 16'h0000);
      pin(1'b0);
      rd(16'h100A);
      $display("bus inverted test done");
   endtask
   task automatic t_under_over();
      wr(6'h06, 16'h0000);
      wr(6'h06, 16'h4000);
      dn(16'hFF00, 16'h0000, 16'h0000);
      pin(1'b0);
      rd(16'h4018);
      wr(6'h06, 16'h0000);
      wr(6'h06, 16'h2000);
      dn(16'h0000, 16'h0010, 16'h0000);
      pin(1'b1);
      dn(16'h0000, 16'h0300, 16'h0000);
      rd(16'h2018);
      $display("under over test done");
   endtask
   task automatic t_ready_power();
      wr(6'h06, 16'h0400);
      dn(16'h0000, 16'h0000, 16'h0000);
      rd(16'h0408);
      dn(16'h0000, 16'h0000, 16'h0000);
      pin(1'b0);
      rd(16'h0408);
      pin(1'b1);
      wr(6'h06, 16'h0800);
      dn(16'h0000, 16'h0000, 16'h0100);
      pin(1'b0);
      @(posedge clk_in);
      config_power_down_only_in <= 1'b1;
      wr(6'h00, 16'h0000);
      rd(16'h0818);
      @(posedge clk_in);
      config_power_down_only_in <= 1'b0;
      dn(16'h0000, 16'h0000, 16'h0000);
      wr(6'h00, 16'h0000);
      rd(16'h0800);
      $display("ready power test done");
   endtask
   task automatic t_faults();
      @(posedge clk_in);
      overflow_event_in <= 1'b1;
      storage_error_event_in <= 1'b1;
      @(posedge clk_in);
      overflow_event_in <= 1'b0;
      storage_error_event_in <= 1'b0;
      rd(16'h0824);
      rd(16'h0824);
      @(posedge clk_in);
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(16'h0000);
      pin(1'b1);
      $display("faults test done");
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      t_shunt_latched();
      t_priority();
      t_bus_inverted();
      t_under_over();
      t_ready_power();
      t_faults();
      wrap_up();
   end
endmodule
bind alert_mask_enable alert_mask_enable_sva chk (.*);
